/* File: src/hall_signal_conditioning_path.sv */
// hall signal conditioning datapath with avalon-mm register slave
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module hall_signal_conditioning_path (
  // clock, reset, enable
  input  wire logic                             SYS_CLK_I,
  input  wire logic                             RESET_N_I,
  input  wire logic                             CLK_EN_I,
  // avalon-mm slave
  input  wire logic [4:0]                       AVS_ADDRESS_I,
  input  wire logic                             AVS_READ_I,
  input  wire logic                             AVS_WRITE_I,
  input  wire logic [31:0]                      AVS_WRITEDATA_I,
  input  wire logic [3:0]                       AVS_BYTEENABLE_I,
  output logic [31:0]                           AVS_READDATA_O,
  output logic                                  AVS_WAITREQUEST_O,
  // converter samples
  input  wire logic [hall_path_pkg::HALL_W-1:0] HALL_SAMPLE_I,
  input  wire logic [hall_path_pkg::TEMP_W-1:0] TEMP_SAMPLE_I,
  output logic [1:0]                            RANGE_SELECT_O,
  // dac word stream
  output logic [hall_path_pkg::DAC_W-1:0]       DAC_DATA_O,
  output logic                                  DAC_VALID_O,
  input  wire logic                             DAC_READY_I
);
  import hall_path_pkg::*;

  path_regs_t path_reg;
  path_regs_t path_next;
  dac_word_if word_in ();
  dac_word_if word_out ();

  // code centred on mid scale, used for gain and offset fields
  function automatic logic signed [CODE_W:0] centre_code(input logic [CODE_W-1:0] code);
    centre_code = signed'({1'b0, code}) - signed'({1'b0, CODE_CENTRE});
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  be);
    lane_merge = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
  endfunction

  logic                               bus_req;
  logic [31:0]                        wr_word;
  logic [31:0]                        rd_word;
  logic [31:0]                        ctrl_view;
  logic signed [HALL_W+ACC_FRAC:0]    acc_diff;
  logic signed [HALL_W+ACC_FRAC-1:0]  x_ext;
  logic [2:0]                         lp_shift;
  logic signed [TEMP_W+COEFF_W:0]     lin_full;
  logic signed [2*TEMP_W+2:0]         sq_full;
  logic signed [2*TEMP_W+COEFF_W+2:0] quad_full;
  logic signed [GAIN_W-1:0]           gain_sum;
  logic signed [HALL_W+GAIN_W-1:0]    prod_full;
  logic signed [HALL_W+GAIN_W-1:0]    out_full;
  logic signed [HALL_W+ACC_FRAC:0]    acc_round;

  assign bus_req           = AVS_READ_I || AVS_WRITE_I;
  // one wait cycle: answer lands on the second edge of a request
  assign AVS_WAITREQUEST_O = bus_req && !path_reg.ack;
  assign AVS_READDATA_O    = path_reg.rdata;
  assign RANGE_SELECT_O    = path_reg.range_sel;

  assign word_in.valid = (path_reg.st == ST_EMIT);
  assign word_in.data  = path_reg.result;
  assign DAC_DATA_O    = word_out.data;
  assign DAC_VALID_O   = word_out.valid;
  assign word_out.ready = DAC_READY_I;

  always_comb begin
    path_next = path_reg;
    ctrl_view = 32'h0000_0000;
    ctrl_view[CTRL_RANGE_LSB +: 2] = path_reg.range_sel;
    ctrl_view[CTRL_LP_LSB +: 3]    = path_reg.lp_set;
    rd_word   = 32'h0000_0000;
    wr_word   = 32'h0000_0000;
    acc_diff  = '0;
    x_ext     = '0;
    lp_shift  = 3'h0;
    lin_full  = '0;
    sq_full   = '0;
    quad_full = '0;
    gain_sum  = '0;
    prod_full = '0;
    out_full  = '0;
    acc_round = '0;

    // register slave
    path_next.ack = bus_req && !path_reg.ack;
    if (bus_req && !path_reg.ack) begin
      unique case (AVS_ADDRESS_I)
        CTRL_OFS:   rd_word = ctrl_view;
        GAIN_OFS:   rd_word = 32'({path_reg.gain_code});
        OFFSET_OFS: rd_word = 32'({path_reg.offset_code});
        TREF_OFS:   rd_word = 32'({path_reg.tref});
        TC1_OFS:    rd_word = 32'({path_reg.tc1});
        TC2_OFS:    rd_word = 32'({path_reg.tc2});
        STATUS_OFS: rd_word = {14'h0000, path_reg.sat_hi, path_reg.sat_lo, 4'h0, path_reg.dac_last};
        GEFF_OFS:   rd_word = path_reg.gain_eff;
        default:    rd_word = 32'h0000_0000;
      endcase
      path_next.rdata = AVS_READ_I ? rd_word : 32'h0000_0000;
      if (AVS_WRITE_I) begin
        wr_word = lane_merge(rd_word, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        unique case (AVS_ADDRESS_I)
          CTRL_OFS: begin
            path_next.range_sel = wr_word[CTRL_RANGE_LSB +: 2];
            path_next.lp_set    = wr_word[CTRL_LP_LSB +: 3];
          end
          GAIN_OFS:   path_next.gain_code   = wr_word[CODE_W-1:0];
          OFFSET_OFS: path_next.offset_code = wr_word[CODE_W-1:0];
          TREF_OFS:   path_next.tref        = wr_word[TEMP_W-1:0];
          TC1_OFS:    path_next.tc1         = wr_word[COEFF_W-1:0];
          TC2_OFS:    path_next.tc2         = wr_word[COEFF_W-1:0];
          default:    path_next.tref        = path_reg.tref;
        endcase
      end
    end

    // 16 khz sample strobe
    if (path_reg.tick_cnt == UPDATE_LAST) begin
      path_next.tick_cnt = 12'h000;
    end else begin
      path_next.tick_cnt = path_reg.tick_cnt + 12'h001;
    end

    unique case (path_reg.st)
      ST_IDLE: begin
        // a strobe while a word is still stalled is skipped, not queued
        if (path_reg.tick_cnt == UPDATE_LAST) begin
          path_next.hall_smp = signed'(HALL_SAMPLE_I);
          path_next.tdiff    = signed'({TEMP_SAMPLE_I[TEMP_W-1], TEMP_SAMPLE_I})
                             - signed'({path_reg.tref[TEMP_W-1], path_reg.tref});
          path_next.st       = ST_FILTER;
        end
      end
      ST_FILTER: begin
        // first-order low-pass; steady state equals input, so dc gain is one
        x_ext    = signed'({path_reg.hall_smp, {ACC_FRAC{1'b0}}});
        lp_shift = 3'h7 - path_reg.lp_set;
        acc_diff = signed'({x_ext[HALL_W+ACC_FRAC-1], x_ext})
                 - signed'({path_reg.acc[HALL_W+ACC_FRAC-1], path_reg.acc});
        if (path_reg.lp_set == LP_BYPASS) begin
          path_next.acc = x_ext;
        end else begin
          path_next.acc = path_reg.acc + (HALL_W+ACC_FRAC)'(acc_diff >>> lp_shift);
        end
        path_next.st = ST_GAIN;
      end
      ST_GAIN: begin
        lin_full  = path_reg.tdiff * signed'(path_reg.tc1);
        sq_full   = path_reg.tdiff * path_reg.tdiff;
        quad_full = sq_full * signed'(path_reg.tc2);
        // gain in q12: code-16384 counts of 1/4096
        gain_sum  = GAIN_W'(centre_code(path_reg.gain_code))
                  + GAIN_W'(lin_full >>> LIN_SHIFT)
                  + GAIN_W'(quad_full >>> QUAD_SHIFT);
        path_next.gain_eff = gain_sum;
        path_next.st       = ST_SCALE;
      end
      ST_SCALE: begin
        // rounded, so a slowly rising input settles on its value, not one below
        acc_round = signed'({path_reg.acc[HALL_W+ACC_FRAC-1], path_reg.acc})
                  + (HALL_W+ACC_FRAC+1)'(2 ** (ACC_FRAC - 1));
        prod_full = signed'(acc_round[HALL_W+ACC_FRAC-1:ACC_FRAC]) * path_reg.gain_eff;
        // offset code-16384 is directly in dac codes at 4096 full scale
        out_full  = (prod_full >>> GAIN_FRAC)
                  + (HALL_W+GAIN_W)'(centre_code(path_reg.offset_code));
        path_next.sat_lo = 1'b0;
        path_next.sat_hi = 1'b0;
        if (out_full < 0) begin
          path_next.result = '0;
          path_next.sat_lo = 1'b1;
        end else if (out_full > (HALL_W+GAIN_W)'(DAC_MAX)) begin
          path_next.result = DAC_MAX;
          path_next.sat_hi = 1'b1;
        end else begin
          path_next.result = out_full[DAC_W-1:0];
        end
        path_next.st = ST_EMIT;
      end
      ST_EMIT: begin
        // held until the buffer accepts, so a dac stall loses nothing
        if (word_in.ready) begin
          path_next.dac_last = path_reg.result;
          path_next.st       = ST_IDLE;
        end
      end
      default: path_next.st = ST_IDLE;
    endcase
  end

  // reset range is mid range, where compensation is pre-matched
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      path_reg <= PATH_RST;
    end else if (CLK_EN_I) begin
      path_reg <= path_next;
    end
  end

  dac_word_buffer u_buffer (
    .clk_i     (SYS_CLK_I),
    .reset_n_i (RESET_N_I),
    .clk_en_i  (CLK_EN_I),
    .in_if     (word_in.snk),
    .out_if    (word_out.src)
  );

endmodule

/* File: src/hall_path_pkg.sv */
// shared constants, register map and types for the hall conditioning path
package hall_path_pkg;

  // clocking and update rate
  localparam int unsigned SYS_CLK_HZ      = 40_000_000;
  localparam int unsigned UPDATE_RATE_HZ  = 16_000;
  localparam int unsigned UPDATE_CYCLES   = SYS_CLK_HZ / UPDATE_RATE_HZ;
  localparam logic [11:0] UPDATE_LAST     = 12'(UPDATE_CYCLES - 1);

  // datapath widths
  localparam int unsigned HALL_W   = 16;
  localparam int unsigned TEMP_W   = 12;
  localparam int unsigned DAC_W    = 12;
  localparam int unsigned CODE_W   = 15;
  localparam int unsigned COEFF_W  = 16;
  localparam int unsigned GAIN_W   = 32;
  localparam int unsigned ACC_FRAC = 8;

  // fixed-point scaling
  localparam logic [CODE_W-1:0] CODE_CENTRE = 15'h4000;
  localparam int unsigned       GAIN_FRAC   = 12;
  localparam int unsigned       LIN_SHIFT   = 8;
  localparam int unsigned       QUAD_SHIFT  = 16;
  localparam logic [DAC_W-1:0]  DAC_MAX     = 12'hFFF;

  // range codes and lowpass bypass code
  localparam logic [1:0] RANGE_50MT  = 2'h3;
  localparam logic [1:0] RANGE_100MT = 2'h1;
  localparam logic [1:0] RANGE_200MT = 2'h0;
  localparam logic [2:0] LP_BYPASS   = 3'h7;

  // register byte offsets
  localparam logic [4:0] CTRL_OFS    = 5'h00;
  localparam logic [4:0] GAIN_OFS    = 5'h04;
  localparam logic [4:0] OFFSET_OFS  = 5'h08;
  localparam logic [4:0] TREF_OFS    = 5'h0C;
  localparam logic [4:0] TC1_OFS     = 5'h10;
  localparam logic [4:0] TC2_OFS     = 5'h14;
  localparam logic [4:0] STATUS_OFS  = 5'h18;
  localparam logic [4:0] GEFF_OFS    = 5'h1C;

  // field positions in control and status
  localparam int unsigned CTRL_RANGE_LSB = 0;
  localparam int unsigned CTRL_LP_LSB    = 4;
  localparam int unsigned STAT_SAT_LO    = 16;
  localparam int unsigned STAT_SAT_HI    = 17;

  // values after reset
  localparam logic [1:0]        RANGE_RST  = RANGE_100MT;
  localparam logic [2:0]        LP_RST     = 3'h1;
  localparam logic [CODE_W-1:0] GAIN_RST   = 15'h5800;
  localparam logic [CODE_W-1:0] OFFSET_RST = 15'h4800;
  localparam logic [TEMP_W-1:0] TREF_RST   = 12'h000;
  localparam logic [COEFF_W-1:0] TC1_RST   = 16'h0000;
  localparam logic [COEFF_W-1:0] TC2_RST   = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FILTER,
    ST_GAIN,
    ST_SCALE,
    ST_EMIT
  } path_state_t;

  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic [1:0]                range_sel;
    logic [2:0]                lp_set;
    logic [CODE_W-1:0]         gain_code;
    logic [CODE_W-1:0]         offset_code;
    logic [TEMP_W-1:0]         tref;
    logic [COEFF_W-1:0]        tc1;
    logic [COEFF_W-1:0]        tc2;
    logic [11:0]               tick_cnt;
    path_state_t               st;
    logic signed [HALL_W-1:0]  hall_smp;
    logic signed [TEMP_W:0]    tdiff;
    logic signed [HALL_W+ACC_FRAC-1:0] acc;
    logic signed [GAIN_W-1:0]  gain_eff;
    logic [DAC_W-1:0]          result;
    logic                      sat_lo;
    logic                      sat_hi;
    logic [DAC_W-1:0]          dac_last;
  } path_regs_t;

  localparam path_regs_t PATH_RST = '{
    ack: 1'b0, rdata: 32'h0000_0000, range_sel: RANGE_RST, lp_set: LP_RST,
    gain_code: GAIN_RST, offset_code: OFFSET_RST, tref: TREF_RST,
    tc1: TC1_RST, tc2: TC2_RST, tick_cnt: 12'h000, st: ST_IDLE,
    hall_smp: '0, tdiff: '0, acc: '0, gain_eff: '0, result: '0,
    sat_lo: 1'b0, sat_hi: 1'b0, dac_last: '0
  };

  typedef struct packed {
    logic [1:0][DAC_W-1:0] mem;
    logic                  wr_ptr;
    logic                  rd_ptr;
    logic [1:0]            count;
  } buf_regs_t;

  localparam buf_regs_t BUF_RST = '{mem: '0, wr_ptr: 1'b0, rd_ptr: 1'b0, count: 2'h0};

endpackage

/* File: src/dac_word_if.sv */
// valid/ready carrier for 12-bit output words between path modules
`timescale 1ns/100ps
interface dac_word_if;
  import hall_path_pkg::*;
  logic [DAC_W-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: src/dac_word_buffer.sv */
// two-entry buffer between limiter and dac port
`timescale 1ns/100ps
module dac_word_buffer (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   reset_n_i,
  input  wire logic   clk_en_i,
  // streams
  dac_word_if.snk     in_if,
  dac_word_if.src     out_if
);
  import hall_path_pkg::*;

  buf_regs_t buf_reg;
  buf_regs_t buf_next;
  logic      push;
  logic      pop;

  assign in_if.ready  = (buf_reg.count != 2'h2);
  assign out_if.valid = (buf_reg.count != 2'h0);
  assign out_if.data  = buf_reg.mem[buf_reg.rd_ptr];

  always_comb begin
    buf_next = buf_reg;
    push     = in_if.valid && in_if.ready;
    pop      = out_if.valid && out_if.ready;
    if (push) begin
      buf_next.mem[buf_reg.wr_ptr] = in_if.data;
      buf_next.wr_ptr              = ~buf_reg.wr_ptr;
    end
    if (pop) begin
      buf_next.rd_ptr = ~buf_reg.rd_ptr;
    end
    unique case ({push, pop})
      2'b10:   buf_next.count = buf_reg.count + 2'h1;
      2'b01:   buf_next.count = buf_reg.count - 2'h1;
      default: buf_next.count = buf_reg.count;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_reg <= BUF_RST;
    end else if (clk_en_i) begin
      buf_reg <= buf_next;
    end
  end

endmodule

/* File: verification/hall_path_props.sv */
// port-level checks for the hall conditioning path
`timescale 1ns/100ps
module hall_path_props (
  // clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_N_I,
  // register bus
  input wire logic [4:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // converter and dac side
  input wire logic [1:0]  RANGE_SELECT_O,
  input wire logic [11:0] DAC_DATA_O,
  input wire logic        DAC_VALID_O,
  input wire logic        DAC_READY_I
);
  import hall_path_pkg::*;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic [15:0] gap_reg;
  logic        rd_done;
  assign rd_done = AVS_READ_I && !AVS_WAITREQUEST_O;
  // saturates so the first rise after reset always passes
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      gap_reg <= 16'hFFFF;
    end else if ($rose(DAC_VALID_O)) begin
      gap_reg <= 16'h0000;
    end else if (gap_reg != 16'hFFFF) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  sequence req_first;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence req_answered;
    !AVS_WAITREQUEST_O;
  endsequence
  bus_answer_a: assert property (req_first |=> req_answered)
    else $error("waitrequest not released");
  bus_idle_a: assert property (!(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O)
    else $error("waitrequest without request");
  word_hold_a: assert property (DAC_VALID_O && !DAC_READY_I |=> DAC_VALID_O && $stable(DAC_DATA_O))
    else $error("dac word lost in stall");
  range_hold_a: assert property (!$stable(RANGE_SELECT_O) |-> $past(AVS_WRITE_I && AVS_ADDRESS_I == CTRL_OFS))
    else $error("range changed without write");
  ctrl_range_a: assert property (rd_done && AVS_ADDRESS_I == CTRL_OFS |-> AVS_READDATA_O[1:0] == RANGE_SELECT_O)
    else $error("range pin differs from field");
  sat_flag_a: assert property (rd_done && AVS_ADDRESS_I == STATUS_OFS |->
    (!AVS_READDATA_O[STAT_SAT_LO] || AVS_READDATA_O[11:0] == 12'h000) &&
    (!AVS_READDATA_O[STAT_SAT_HI] || AVS_READDATA_O[11:0] == DAC_MAX))
    else $error("saturation flag with wrong word");
  code_width_a: assert property (rd_done && (AVS_ADDRESS_I == GAIN_OFS || AVS_ADDRESS_I == OFFSET_OFS)
    |-> AVS_READDATA_O[31:15] == 17'h00000)
    else $error("code field wider than 15 bits");
  word_pace_a: assert property ($rose(DAC_VALID_O) |-> gap_reg >= 16'h09C3)
    else $error("dac words faster than update rate");
endmodule
bind hall_signal_conditioning_path hall_path_props u_props (
  .SYS_CLK_I         (SYS_CLK_I),
  .RESET_N_I         (RESET_N_I),
  .AVS_ADDRESS_I     (AVS_ADDRESS_I),
  .AVS_READ_I        (AVS_READ_I),
  .AVS_WRITE_I       (AVS_WRITE_I),
  .AVS_READDATA_O    (AVS_READDATA_O),
  .AVS_WAITREQUEST_O (AVS_WAITREQUEST_O),
  .RANGE_SELECT_O    (RANGE_SELECT_O),
  .DAC_DATA_O        (DAC_DATA_O),
  .DAC_VALID_O       (DAC_VALID_O),
  .DAC_READY_I       (DAC_READY_I)
);

/* File: verification/dac_receiver_model.sv */
// dac receiver model with random and commanded stalls
`timescale 1ns/100ps
module dac_receiver_model (
  // clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  // word stream
  input  wire logic [hall_path_pkg::DAC_W-1:0] data_i,
  input  wire logic                            valid_i,
  output logic                                 ready_o,
  // control and observation
  input  wire logic                            stall_i,
  output logic                                 took_o,
  output logic [hall_path_pkg::DAC_W-1:0]      word_o
);
  import hall_path_pkg::*;
  // ready drops at random so the path must hold its word
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_o <= 1'b0;
      took_o <= 1'b0;
      word_o <= '0;
    end else begin
      took_o <= valid_i && ready_o;
      word_o <= data_i;
      ready_o <= !stall_i && ($urandom_range(3) != 0);
    end
  end
endmodule

/* File: verification/hall_signal_conditioning_path_tb_top.sv */
// random and corner tests of the hall conditioning path
`timescale 1ns/100ps
module hall_signal_conditioning_path_tb_top;
  import hall_path_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] hall = 16'h0;
  logic [11:0] temp = 12'h0;
  logic        stall = 1'b0;
  logic [31:0] rdata, q, exp_stat, exp_gain;
  logic [11:0] dac_data, word, exp_word;
  logic [1:0]  range_sel;
  logic        waitreq, dac_valid, dac_ready, took;
  logic [1:0]  rng [3] = '{RANGE_50MT, RANGE_100MT, RANGE_200MT};
  logic [4:0]  rst_ofs [6] = '{CTRL_OFS, GAIN_OFS, OFFSET_OFS, TREF_OFS, TC1_OFS, TC2_OFS};
  int          n_mismatch = 0;
  int          checks = 0;
  int          g, os, tref, tc1, tc2, x, t;
  always #12.5 clk = ~clk;
  hall_signal_conditioning_path u_dut (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .HALL_SAMPLE_I(hall), .TEMP_SAMPLE_I(temp), .RANGE_SELECT_O(range_sel),
    .DAC_DATA_O(dac_data), .DAC_VALID_O(dac_valid), .DAC_READY_I(dac_ready));
  dac_receiver_model u_rx (
    .clk_i(clk), .reset_n_i(rst_n), .data_i(dac_data), .valid_i(dac_valid), .ready_o(dac_ready),
    .stall_i(stall), .took_o(took), .word_o(word));
  task automatic fail(input string msg);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("dac word got %h exp %h", got, exp));
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    // waitrequest and read data are both taken at the edge that ends the request
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 64) fail("bus hang");
  endtask
  task automatic next_word();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (took !== 1'b1 && n < 8000);
    if (n >= 8000) fail("no dac word");
  endtask
  task automatic predict();
    longint d, gn, y;
    d = t - tref;
    gn = (g - 16384) + ((d * tc1) >>> 8) + ((d * d * tc2) >>> 16);
    y = ((x * gn) >>> 12) + (os - 16384);
    exp_gain = 32'(gn);
    exp_word = y < 0 ? 12'h000 : (y > 4095 ? DAC_MAX : 12'(y));
    exp_stat = {14'h0000, y > 4095, y < 0, 4'h0, exp_word};
  endtask
  task automatic apply(input int lp, input logic [1:0] r, input int xin);
    bus(1, CTRL_OFS, (32'(lp) << CTRL_LP_LSB) | 32'(r));
    bus(1, GAIN_OFS, 32'(g));
    bus(1, OFFSET_OFS, 32'(os));
    bus(1, TREF_OFS, 32'(tref));
    bus(1, TC1_OFS, 32'(tc1));
    bus(1, TC2_OFS, 32'(tc2));
    @(posedge clk);
    hall <= 16'(xin);
    temp <= 12'(t);
    predict();
  endtask
  task automatic reset_scan();
    logic [31:0] v [6];
    v = '{(32'(LP_RST) << CTRL_LP_LSB) | 32'(RANGE_RST), 32'(GAIN_RST), 32'(OFFSET_RST),
          32'(TREF_RST), 32'(TC1_RST), 32'(TC2_RST)};
    foreach (v[k]) begin
      bus(0, rst_ofs[k], '0);
      chk_reg(q, v[k], "reset value");
    end
    chk_reg(32'(range_sel), 32'(RANGE_100MT), "reset range");
    $display("test reset values done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    // tests need about 26 update periods; this allows 38
    repeat (95000) @(posedge clk);
    fail("watchdog expired");
    complete_run();
  end
  initial begin
    void'($urandom(19470));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    reset_scan();
    for (int i = 0; i < 8; i++) begin
      bus(1, CTRL_OFS, (32'(i) << CTRL_LP_LSB) | 32'(rng[i % 3]));
      bus(0, CTRL_OFS, '0);
      chk_reg(q, (32'(i) << CTRL_LP_LSB) | 32'(rng[i % 3]), "ctrl");
      chk_reg(32'(range_sel), 32'(rng[i % 3]), "range pin");
    end
    $display("test range and lowpass codes done");
    g = 20480;
    os = 16384;
    tref = 0;
    t = 0;
    tc1 = 0;
    tc2 = 0;
    apply(6, RANGE_100MT, 0);
    next_word();
    next_word();
    @(posedge clk);
    hall <= 16'h0400;
    x = 512;
    predict();
    next_word();
    chk_word(word, exp_word);
    x = 768;
    predict();
    next_word();
    chk_word(word, exp_word);
    $display("test lowpass step done");
    for (int i = 0; i < 9; i++) begin
      g = $urandom_range(32767);
      os = $urandom_range(18432, 14336);
      tref = $urandom_range(400) - 200;
      t = $urandom_range(400) - 200;
      tc1 = $urandom_range(4095) - 2048;
      tc2 = $urandom_range(511) - 256;
      x = $urandom_range(4000) - 2000;
      // extreme corners for saturation and wide intermediates
      if (i == 0) begin
        x = 32767;
        g = 32767;
        tc1 = 32767;
      end
      if (i == 1) begin
        x = -32768;
        os = 0;
      end
      apply(7, rng[i % 3], x);
      next_word();
      next_word();
      chk_word(word, exp_word);
      bus(0, STATUS_OFS, '0);
      chk_reg(q, exp_stat, "status");
      bus(0, GEFF_OFS, '0);
      chk_reg(q, exp_gain, "effective gain");
      bus(0, GAIN_OFS, '0);
      chk_reg(q, 32'(g), "gain code");
    end
    $display("test random datapath done");
    @(posedge clk);
    stall <= 1'b1;
    repeat (7600) @(posedge clk);
    stall <= 1'b0;
    next_word();
    chk_word(word, exp_word);
    next_word();
    chk_word(word, exp_word);
    $display("test receiver stall done");
    bus(1, STATUS_OFS, 32'hFFFF_FFFF);
    bus(1, 5'h02, 32'hFFFF_FFFF);
    bus(0, STATUS_OFS, '0);
    chk_reg(q, exp_stat, "status read-only");
    bus(0, 5'h02, '0);
    chk_reg(q, 32'h0000_0000, "unmapped");
    $display("test refused access done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reset_scan();
    complete_run();
  end
endmodule
